// ---- psrw_pkg.sv ----
package psrw_pkg;
  localparam int NUM_COUNTERS = 8;
  localparam int NUM_SAMPLING = 4;
  localparam int REC_WORDS = 24;
  localparam int IDX_W = 5;
  localparam logic [4:0] IDX_LAST = 5'h17;
  localparam logic [4:0] IDX_GPR0 = 5'h02;
  localparam logic [4:0] IDX_GPR15 = 5'h11;
  // record byte offsets
  localparam logic [7:0] OFF_FLAGS = 8'h00;
  localparam logic [7:0] OFF_IP = 8'h08;
  localparam logic [7:0] OFF_GPR15 = 8'h88;
  localparam logic [7:0] OFF_GSTAT = 8'h90;
  localparam logic [7:0] OFF_DLA = 8'h98;
  localparam logic [7:0] OFF_DSRC = 8'hA0;
  localparam logic [7:0] OFF_LAT = 8'hA8;
  localparam logic [7:0] OFF_EIP = 8'hB0;
  localparam logic [7:0] OFF_ABORT = 8'hB8;
  localparam int STORE_HIT_BIT = 0;
  // register byte addresses
  localparam logic [7:0] REG_ENABLE = 8'h00;
  localparam logic [7:0] REG_CAP = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_COUNT = 8'h0C;
  localparam logic [7:0] REG_DROP = 8'h10;
  localparam logic [7:0] ENABLE_MASK = 8'h0F;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam int CAP_WIDE_BIT = 2;
  localparam logic [31:0] CAP_VALUE = 32'h00000004;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic [63:0] flags;
    logic [63:0] eventing_ip;
    logic [3:0] insn_len;
    logic [3:0] fused_len;
    logic fused;
    logic [15:0][63:0] gpr;
    logic [63:0] mem_addr;
    logic mem_valid;
    logic is_store;
    logic store_l1_hit;
    logic addr_event;
    logic [63:0] abort_info;
  } psrw_retire_t;

  typedef struct packed {
    logic [63:0] flags;
    logic [63:0] next_ip;
    logic [15:0][63:0] gpr;
    logic [63:0] gstat;
    logic [63:0] dla;
    logic [63:0] dsrc;
    logic [63:0] eip;
    logic [63:0] abort_info;
  } psrw_snap_t;
endpackage

// ---- psrw_writer.sv ----
`timescale 1ns/10ps
`default_nettype none
module psrw_writer (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // core events
  input wire logic [7:0] counter_overflow,
  input wire logic [63:0] global_counter_status,
  input wire psrw_pkg::psrw_retire_t retire,
  // record stream
  output logic rec_valid,
  input wire logic rec_ready,
  output logic [7:0] rec_offset,
  output logic [63:0] rec_data,
  output logic rec_last
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  typedef enum logic [1:0] {IDLE, ARM, EMIT} psrw_state_t;
  psrw_state_t state_reg;
  logic [7:0] enable_reg;
  logic [31:0] count_reg;
  logic [31:0] drop_reg;
  psrw_pkg::psrw_snap_t snap_reg;
  psrw_pkg::psrw_snap_t snap_next;
  logic [4:0] idx_reg;
  logic [7:0] aw_addr_reg;
  logic aw_hold_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_hold_reg;
  logic trig;
  logic do_write;
  logic [31:0] rd_value;
  logic [1:0] rd_resp;
  logic [7:0] sample_ovf;

  // counters four to seven never reach the trigger
  assign sample_ovf = counter_overflow & psrw_pkg::ENABLE_MASK & enable_reg;
  assign trig = (state_reg == IDLE) && (sample_ovf != 8'h00);

  // ----------------------------------------
  // snapshot of the retiring state
  // ----------------------------------------
  // one layout regardless of operating mode
  always_comb begin
    snap_next.flags = retire.flags;
    snap_next.next_ip = retire.eventing_ip + 64'(retire.insn_len)
        + (retire.fused ? 64'(retire.fused_len) : 64'h0);
    snap_next.gpr = retire.gpr;
    snap_next.gstat = global_counter_status;
    snap_next.dla = 64'h0;
    snap_next.dsrc = 64'h0;
    if (retire.mem_valid && retire.addr_event) begin
      snap_next.dla = retire.mem_addr;
      if (retire.is_store) begin
        snap_next.dsrc[psrw_pkg::STORE_HIT_BIT] = retire.store_l1_hit;
      end
    end
    snap_next.eip = retire.eventing_ip;
    snap_next.abort_info = retire.abort_info;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      snap_reg <= '0;
    end else if (trig) begin
      snap_reg <= snap_next;
    end
  end

  function automatic logic [63:0] rec_word(input psrw_pkg::psrw_snap_t s,
                                           input logic [4:0] i);
    logic [63:0] w;
    w = 64'h0;
    unique case (i)
      5'h00: w = s.flags;
      5'h01: w = s.next_ip;
      5'h12: w = s.gstat;
      5'h13: w = s.dla;
      5'h14: w = s.dsrc;
      5'h15: w = 64'h0;
      5'h16: w = s.eip;
      5'h17: w = s.abort_info;
      default: begin
        if (i >= psrw_pkg::IDX_GPR0 && i <= psrw_pkg::IDX_GPR15) begin
          w = s.gpr[4'(i - psrw_pkg::IDX_GPR0)];
        end
      end
    endcase
    return w;
  endfunction

  // ----------------------------------------
  // record emission
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_reg <= IDLE;
      idx_reg <= 5'h00;
      rec_valid <= 1'b0;
      rec_offset <= 8'h00;
      rec_data <= 64'h0;
      rec_last <= 1'b0;
    end else begin
      unique case (state_reg)
        IDLE: begin
          if (trig) begin
            state_reg <= ARM;
          end
        end
        ARM: begin
          idx_reg <= 5'h00;
          rec_valid <= 1'b1;
          rec_offset <= 8'h00;
          rec_data <= rec_word(snap_reg, 5'h00);
          rec_last <= 1'b0;
          state_reg <= EMIT;
        end
        EMIT: begin
          if (rec_ready) begin
            if (idx_reg == psrw_pkg::IDX_LAST) begin
              rec_valid <= 1'b0;
              rec_last <= 1'b0;
              state_reg <= IDLE;
            end else begin
              idx_reg <= idx_reg + 5'h01;
              rec_offset <= {idx_reg + 5'h01, 3'h0};
              rec_data <= rec_word(snap_reg, idx_reg + 5'h01);
              rec_last <= (idx_reg + 5'h01) == psrw_pkg::IDX_LAST;
            end
          end
        end
      endcase
    end
  end

  // records completed and overflows lost while busy
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_reg <= 32'h0;
      drop_reg <= 32'h0;
    end else begin
      if (state_reg == EMIT && rec_ready && idx_reg == psrw_pkg::IDX_LAST) begin
        count_reg <= count_reg + 32'h1;
      end
      if (state_reg != IDLE && sample_ovf != 8'h00) begin
        drop_reg <= drop_reg + 32'h1;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite write path
  // ----------------------------------------
  assign do_write = aw_hold_reg && w_hold_reg && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      aw_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      s_axi_awready <= 1'b0;
      aw_hold_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (do_write) begin
      aw_hold_reg <= 1'b0;
    end else if (!aw_hold_reg && !s_axi_bvalid) begin
      s_axi_awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_wready <= 1'b0;
      w_hold_reg <= 1'b0;
      w_data_reg <= 32'h0;
      w_strb_reg <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      s_axi_wready <= 1'b0;
      w_hold_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_reg <= 1'b0;
    end else if (!w_hold_reg && !s_axi_bvalid) begin
      s_axi_wready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= psrw_pkg::RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      if (aw_addr_reg[7:2] <= psrw_pkg::REG_DROP[7:2]) begin
        s_axi_bresp <= psrw_pkg::RESP_OKAY;
      end else begin
        s_axi_bresp <= psrw_pkg::RESP_SLVERR;
      end
    end else if (s_axi_bvalid && s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // only the four sampling bits are writable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_reg <= psrw_pkg::ENABLE_RESET;
    end else if (do_write && aw_addr_reg[7:2] == psrw_pkg::REG_ENABLE[7:2]
                 && w_strb_reg[0]) begin
      enable_reg <= w_data_reg[7:0] & psrw_pkg::ENABLE_MASK;
    end
  end

  // ----------------------------------------
  // axi4-lite read path
  // ----------------------------------------
  always_comb begin
    rd_value = 32'h0;
    rd_resp = psrw_pkg::RESP_OKAY;
    unique case (s_axi_araddr[7:2])
      psrw_pkg::REG_ENABLE[7:2]: rd_value = {24'h0, enable_reg};
      psrw_pkg::REG_CAP[7:2]: rd_value = psrw_pkg::CAP_VALUE;
      psrw_pkg::REG_STATUS[7:2]: rd_value = {30'h0, state_reg};
      psrw_pkg::REG_COUNT[7:2]: rd_value = count_reg;
      psrw_pkg::REG_DROP[7:2]: rd_value = drop_reg;
      default: rd_resp = psrw_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= psrw_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_value;
      s_axi_rresp <= rd_resp;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  logic rd_cap_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_cap_q <= 1'b0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      rd_cap_q <= s_axi_araddr[7:2] == psrw_pkg::REG_CAP[7:2];
    end
  end

  sequence s_arm;
    state_reg == ARM ##1 rec_valid && rec_offset == psrw_pkg::OFF_FLAGS;
  endsequence

  property p_high_ctr;
    @(posedge aclk) disable iff (!aresetn)
      state_reg == IDLE && counter_overflow[3:0] == 4'h0 |=> state_reg == IDLE;
  endproperty
  a_high_ctr: assert property (p_high_ctr) else $error("high counter started record");

  property p_cap;
    @(posedge aclk) disable iff (!aresetn)
      s_axi_rvalid && rd_cap_q |-> s_axi_rdata[psrw_pkg::CAP_WIDE_BIT];
  endproperty
  a_cap: assert property (p_cap) else $error("wide format bit clear");

  property p_start;
    @(posedge aclk) disable iff (!aresetn)
      trig |=> s_arm;
  endproperty
  a_start: assert property (p_start) else $error("overflow did not start record");

  property p_offset;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid |-> rec_offset == {idx_reg, 3'h0} && rec_last == (idx_reg == 5'h17);
  endproperty
  a_offset: assert property (p_offset) else $error("word offset wrong");

  property p_hold;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid && !rec_ready |=> rec_valid && $stable(rec_data) && $stable(rec_offset);
  endproperty
  a_hold: assert property (p_hold) else $error("record word changed while stalled");

  property p_gpr15;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid && rec_offset == psrw_pkg::OFF_GPR15 |-> rec_data == snap_reg.gpr[15];
  endproperty
  a_gpr15: assert property (p_gpr15) else $error("register fifteen misplaced");

  property p_lat;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid && rec_offset == psrw_pkg::OFF_LAT |-> rec_data == 64'h0;
  endproperty
  a_lat: assert property (p_lat) else $error("latency field not zero");

  property p_dsrc;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid && rec_offset == psrw_pkg::OFF_DSRC |-> rec_data[63:1] == 63'h0;
  endproperty
  a_dsrc: assert property (p_dsrc) else $error("store status upper bits set");

  property p_eip;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid && rec_offset == psrw_pkg::OFF_EIP |-> rec_data == snap_reg.eip;
  endproperty
  a_eip: assert property (p_eip) else $error("triggering pointer wrong");

  property p_abort;
    @(posedge aclk) disable iff (!aresetn)
      rec_valid && rec_offset == psrw_pkg::OFF_ABORT |-> rec_data == snap_reg.abort_info;
  endproperty
  a_abort: assert property (p_abort) else $error("abort information wrong");

  property p_nip;
    @(posedge aclk) disable iff (!aresetn)
      trig && !retire.fused |=> snap_reg.next_ip == snap_reg.eip
          + 64'($past(retire.insn_len));
  endproperty
  a_nip: assert property (p_nip) else $error("next pointer skid wrong");

  property p_dla;
    @(posedge aclk) disable iff (!aresetn)
      trig && !retire.addr_event |=> snap_reg.dla == 64'h0 && snap_reg.dsrc == 64'h0;
  endproperty
  a_dla: assert property (p_dla) else $error("address captured for other event");

  property p_gstat;
    @(posedge aclk) disable iff (!aresetn)
      trig |=> snap_reg.gstat == $past(global_counter_status);
  endproperty
  a_gstat: assert property (p_gstat) else $error("status snapshot wrong");

endmodule
`default_nettype wire

// ---- psrw_sink.sv ----
`timescale 1ns/10ps
`default_nettype none
module psrw_sink (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // record stream
  input wire logic rec_valid,
  output logic rec_ready,
  input wire logic [7:0] rec_offset,
  input wire logic [63:0] rec_data,
  input wire logic rec_last,
  // bench control
  input wire logic stall,
  input wire logic clr,
  output logic [7:0] words
);
  logic [63:0] mem [32];
  logic [7:0] off [32];
  logic lst [32];
  // ----------------
  // buffer acceptance
  // ----------------
  // a slow buffer takes a word only every other cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rec_ready <= 1'b0;
    end else begin
      rec_ready <= stall ? ~rec_ready : 1'b1;
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      words <= 8'h00;
    end else if (rec_valid && rec_ready) begin
      mem[words[4:0]] <= rec_data;
      off[words[4:0]] <= rec_offset;
      lst[words[4:0]] <= rec_last;
      words <= words + 8'h01;
    end
  end
endmodule
`default_nettype wire

// ---- psrw_writer_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module psrw_writer_bench;
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] ovf;
    logic store;
    logic hit;
    logic fused;
    logic aev;
    logic stall;
    logic rec;
  } psrw_row_t;
  localparam logic [63:0] FLAGS = 64'h0000_0000_0000_0246;
  localparam logic [63:0] EIP = 64'h0000_7F00_0040_1000;
  localparam logic [63:0] ADDR = 64'hFFFF_8000_1234_5678;
  localparam logic [63:0] ABORT = 64'h0000_0000_0000_00C3;
  localparam logic [63:0] GSTAT = 64'h0000_0001_0000_000F;
  localparam logic [63:0] GPR0 = 64'h0123_4567_89AB_0000;
  localparam psrw_row_t ROWS [6] = '{
    '{8'h01, 8'h01, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1},
    '{8'h08, 8'h08, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1},
    '{8'h04, 8'h04, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1},
    '{8'h02, 8'h02, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1},
    '{8'hFF, 8'hF0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0},
    '{8'h01, 8'h06, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0}};
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, rec_valid, rec_ready, rec_last, stall, clr;
  logic [7:0] s_axi_awaddr, s_axi_araddr, counter_overflow, rec_offset, words;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, resp;
  logic [63:0] global_counter_status, rec_data, rd;
  psrw_pkg::psrw_retire_t retire;
  int miscompares = 0;
  int total_checks = 0;
  int cycles = 0;

  psrw_writer DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .counter_overflow, .global_counter_status, .retire,
    .rec_valid, .rec_ready, .rec_offset, .rec_data, .rec_last);
  psrw_sink SINK (.aclk, .aresetn, .rec_valid, .rec_ready, .rec_offset, .rec_data,
    .rec_last, .stall, .clr, .words);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end
  // ----------------
  // shared tasks
  // ----------------
  task automatic complete_run();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      miscompares++;
      complete_run();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (s_axi_awready) begin
        ad = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        wd = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = {32'h0, s_axi_rdata};
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    chk(rd, {32'h0, e});
    chk({62'h0, resp}, {62'h0, er});
  endtask
  // status word differs only in the trigger cycle, so a late snapshot shows
  task automatic pulse(input logic [7:0] v);
    @(posedge aclk);
    counter_overflow <= v;
    global_counter_status <= GSTAT ^ {56'h00, v};
    @(posedge aclk);
    counter_overflow <= 8'h00;
    global_counter_status <= GSTAT;
  endtask
  task automatic wait_rec();
    int n;
    n = 0;
    while (words !== 8'h18 && n < 200) begin
      @(posedge aclk);
      n++;
    end
    repeat (5) @(posedge aclk);
  endtask
  function automatic psrw_pkg::psrw_retire_t mk(input psrw_row_t r);
    psrw_pkg::psrw_retire_t t;
    t = '0;
    t.flags = FLAGS;
    t.eventing_ip = EIP;
    t.insn_len = 4'h3;
    t.fused_len = 4'h2;
    t.fused = r.fused;
    for (int g = 0; g < 16; g++) t.gpr[g] = GPR0 + 64'(g);
    t.mem_addr = ADDR;
    t.mem_valid = 1'b1;
    t.is_store = r.store;
    t.store_l1_hit = r.hit;
    t.addr_event = r.aev;
    t.abort_info = ABORT;
    return t;
  endfunction
  function automatic logic [63:0] expw(input int i, input psrw_row_t r);
    case (i)
      0: return FLAGS;
      1: return EIP + (r.fused ? 64'h5 : 64'h3);
      18: return GSTAT ^ {56'h00, r.ovf};
      19: return r.aev ? ADDR : 64'h0;
      20: return {63'h0, r.store & r.hit & r.aev};
      21: return 64'h0;
      22: return EIP;
      23: return ABORT;
      default: return GPR0 + 64'(i - 2);
    endcase
  endfunction
  task automatic chk_rec(input psrw_row_t r);
    for (int i = 0; i < 24; i++) begin
      chk(SINK.mem[i], expw(i, r));
      chk({56'h0, SINK.off[i]}, 64'(i * 8));
      chk({63'h0, SINK.lst[i]}, {63'h0, i == 23});
    end
  endtask
  task automatic arm(input psrw_row_t r);
    @(posedge aclk);
    clr <= 1'b1;
    stall <= r.stall;
    retire <= mk(r);
    @(posedge aclk);
    clr <= 1'b0;
  endtask
  // ----------------
  // main sequence
  // ----------------
  initial begin
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    counter_overflow = 8'h00;
    global_counter_status = GSTAT;
    retire = '0;
    stall = 1'b0;
    clr = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rdchk(psrw_pkg::REG_ENABLE, 32'h0, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_CAP, 32'h4, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_STATUS, 32'h0, psrw_pkg::RESP_OKAY);
    axi_wr(psrw_pkg::REG_CAP, 32'h0);
    rdchk(psrw_pkg::REG_CAP, 32'h4, psrw_pkg::RESP_OKAY);
    axi_wr(8'h14, 32'hF);
    chk({62'h0, resp}, {62'h0, psrw_pkg::RESP_SLVERR});
    rdchk(8'h14, 32'h0, psrw_pkg::RESP_SLVERR);
    axi_wr(psrw_pkg::REG_ENABLE, 32'hFF);
    chk({62'h0, resp}, {62'h0, psrw_pkg::RESP_OKAY});
    rdchk(psrw_pkg::REG_ENABLE, 32'h0F, psrw_pkg::RESP_OKAY);
    for (int k = 0; k < 6; k++) begin
      axi_wr(psrw_pkg::REG_ENABLE, {24'h0, ROWS[k].en});
      arm(ROWS[k]);
      pulse(ROWS[k].ovf);
      wait_rec();
      chk({56'h0, words}, ROWS[k].rec ? 64'h18 : 64'h0);
      if (ROWS[k].rec) begin
        chk_rec(ROWS[k]);
      end
    end
    // second overflow lands while the first record is still going out
    arm(ROWS[0]);
    pulse(8'h01);
    rdchk(psrw_pkg::REG_STATUS, 32'h2, psrw_pkg::RESP_OKAY);
    pulse(8'h01);
    wait_rec();
    chk({56'h0, words}, 64'h18);
    chk_rec(ROWS[0]);
    rdchk(psrw_pkg::REG_DROP, 32'h1, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_COUNT, 32'h5, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_STATUS, 32'h0, psrw_pkg::RESP_OKAY);
    // reset in the middle of a record clears the stream and the registers
    arm(ROWS[0]);
    pulse(8'h01);
    repeat (6) @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    chk({63'h0, rec_valid}, 64'h0);
    chk({56'h0, words}, 64'h0);
    rdchk(psrw_pkg::REG_ENABLE, 32'h0, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_COUNT, 32'h0, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_DROP, 32'h0, psrw_pkg::RESP_OKAY);
    rdchk(psrw_pkg::REG_STATUS, 32'h0, psrw_pkg::RESP_OKAY);
    complete_run();
  end
endmodule
`default_nettype wire
